// File: bench/jsc_assertions.sv
// Port-level checker for the jump and subroutine control block.
`timescale 1ns/1ps
module jsc_checker
  import jsc_pkg::*;
(
  // Clock and reset
  input wire logic          ref_clk_i,
  input wire logic          rst_i,
  // Instruction issue
  input wire logic          instr_valid_i,
  input wire logic [DW-1:0] instr_i,
  input wire logic          ready_o,
  input wire logic          done_o,
  input wire logic          illegal_o,
  input wire logic          boundary_err_o,
  // Memory port
  input wire logic          mem_req_o,
  input wire logic          mem_we_o,
  input wire logic [DW-1:0] mem_addr_o,
  input wire logic          mem_ack_i
);
  logic take;
  logic ctl;
  logic mode0;
  assign take = ready_o && instr_valid_i;
  assign ctl = instr_i[15:6] == OPC_JUMP || instr_i[15:9] == OPC_CALL;
  assign mode0 = instr_i[5:3] == MODE_REG;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_call;
    take && instr_i[15:9] == OPC_CALL &&
      (instr_i[5:3] == MODE_DEF || instr_i[5:3] == MODE_INC);
  endsequence
  sequence s_ret;
    take && instr_i[15:3] == OPC_RETURN;
  endsequence
  AST_MODE0_ILLEGAL: assert property (
    take && ctl && mode0 |=> done_o && illegal_o && ready_o)
    else $error("mode 0 transfer not flagged");
  AST_ILLEGAL_CAUSE: assert property (
    illegal_o |-> $past(take && ctl && mode0))
    else $error("illegal flag without mode 0 transfer");
  AST_JUMP_DEF: assert property (
    take && instr_i[15:6] == OPC_JUMP && instr_i[5:3] == MODE_DEF
    |=> !ready_o && !mem_req_o ##1 done_o)
    else $error("deferred jump timing wrong");
  AST_CALL_PUSH: assert property (
    s_call |-> ##2 mem_req_o && mem_we_o)
    else $error("call did not push");
  AST_RET_POP: assert property (
    s_ret |=> mem_req_o && !mem_we_o)
    else $error("return did not read the stack");
  AST_REQ_HOLD: assert property (
    mem_req_o && !mem_ack_i
    |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("request changed before answer");
  AST_REQ_DROP: assert property (
    mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("request held after answer");
  AST_WRITE_DONE: assert property (
    mem_req_o && mem_we_o && mem_ack_i |-> ##2 done_o)
    else $error("call did not finish after push");
  AST_BOUNDARY_DONE: assert property (
    boundary_err_o |-> done_o)
    else $error("boundary flag outside completion");
  AST_DONE_BOUND: assert property (
    take |-> ##[1:64] done_o)
    else $error("instruction never finished");
endmodule

bind jsc_top jsc_checker jsc_checker_i (
  .ref_clk_i, .rst_i, .instr_valid_i, .instr_i, .ready_o, .done_o,
  .illegal_o, .boundary_err_o, .mem_req_o, .mem_we_o, .mem_addr_o,
  .mem_ack_i
);

// File: bench/jsc_mem_model.sv
// Behavioural system memory holding instructions and stack.
`timescale 1ns/1ps
module jsc_mem_model
  import jsc_pkg::*;
(
  // Clock, reset and answer delay
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic [1:0]    wait_i,
  // Request side
  input  wire logic          mem_req_i,
  input  wire logic          mem_we_i,
  input  wire logic [DW-1:0] mem_addr_i,
  input  wire logic [DW-1:0] mem_wdata_i,
  // Answer side
  output logic               mem_ack_o,
  output logic [DW-1:0]      mem_rdata_o
);
  logic [DW-1:0] mem [1024];
  logic [1:0]    cnt;
  // Idle read data flips every cycle so a stale word never looks valid.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'h0;
      cnt <= 2'h0;
      mem_rdata_o <= 16'h0000;
    end else if (mem_req_i && !mem_ack_o && cnt >= wait_i) begin
      mem_ack_o <= 1'h1;
      cnt <= 2'h0;
      if (mem_we_i) mem[mem_addr_i[10:1]] <= mem_wdata_i;
      mem_rdata_o <= mem[mem_addr_i[10:1]];
    end else begin
      mem_ack_o <= 1'h0;
      cnt <= (mem_req_i && !mem_ack_o) ? cnt + 2'h1 : 2'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// File: bench/jsc_top_bench.sv
// Self-checking bench for the jump and subroutine control block.
`timescale 1ns/1ps
module jsc_top_bench;
  import jsc_pkg::*;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, instr_valid_i = 1'h0;
  logic reg_wr_en_i = 1'h0, ready_o, done_o, illegal_o, boundary_err_o;
  logic [DW-1:0] instr_i = 16'h0000, reg_wr_data_i = 16'h0000;
  logic [RW-1:0] reg_wr_sel_i = 3'h0, reg_rd_sel_i = 3'h0;
  logic [DW-1:0] reg_rd_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic mem_req_o, mem_we_o, mem_ack_i, ill, bnd;
  logic [1:0] wait_i = 2'h0;
  int miscompares = 0, checks_done = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  jsc_top jsc_top_i (.ref_clk_i, .rst_i, .instr_valid_i, .instr_i,
    .ready_o, .done_o, .illegal_o, .boundary_err_o, .reg_wr_en_i,
    .reg_wr_sel_i, .reg_wr_data_i, .reg_rd_sel_i, .reg_rd_data_o,
    .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
    .mem_rdata_i);
  jsc_mem_model jsc_mem_model_i (.ref_clk_i, .rst_i, .wait_i,
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // Write enable is left high so back-to-back preloads need no gap.
  task automatic wr(input logic [RW-1:0] s, input logic [DW-1:0] d);
    reg_wr_en_i = 1'h1;
    reg_wr_sel_i = s;
    reg_wr_data_i = d;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rd(input logic [RW-1:0] s, input logic [DW-1:0] e,
                    input string m);
    reg_wr_en_i = 1'h0;
    reg_rd_sel_i = s;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(reg_rd_data_o, e, m);
  endtask
  task automatic run(input logic [DW-1:0] op);
    reg_wr_en_i = 1'h0;
    instr_i = op;
    instr_valid_i = 1'h1;
    @(posedge ref_clk_i);
    #1;
    instr_valid_i = 1'h0;
    // An illegal or foreign opcode already shows done at this point.
    for (int i = 0; i < 64; i++) begin
      if (done_o === 1'h1) break;
      @(posedge ref_clk_i);
      #1;
    end
    chk(16'(done_o), 16'h0001, "no completion");
    ill = illegal_o;
    bnd = boundary_err_o;
  endtask
  task automatic t_jump();
    wr(3'h2, 16'h0100);
    run(16'h004a);
    chk(16'(bnd), 16'h0000, "even target");
    rd(REG_PC, 16'h0100, "deferred jump");
    wr(3'h3, 16'h0101);
    run(16'h004b);
    chk(16'(bnd), 16'h0001, "odd target");
    rd(REG_PC, 16'h0101, "odd jump");
  endtask
  task automatic t_mode0();
    logic [DW-1:0] ops [2] = '{16'h0042, 16'h0942};
    wr(REG_PC, 16'h0300);
    foreach (ops[i]) begin
      run(ops[i]);
      chk(16'(ill), 16'h0001, "mode 0");
      rd(REG_PC, 16'h0300, "pc kept");
    end
  endtask
  task automatic t_index();
    wait_i = 2'h3;
    jsc_mem_model_i.mem[10'h100] = 16'h0010;
    wr(REG_PC, 16'h0200);
    wr(3'h1, 16'h0300);
    run(16'h0071);
    rd(REG_PC, 16'h0310, "indexed jump");
  endtask
  task automatic t_call_ret();
    wait_i = 2'h1;
    wr(REG_SP, 16'h0400);
    wr(3'h4, 16'h0600);
    wr(REG_PC, 16'h0500);
    run(16'h0914);
    chk(jsc_mem_model_i.mem[10'h1ff], 16'h0602, "pushed");
    rd(REG_SP, 16'h03fe, "sp after call");
    rd(3'h4, 16'h0500, "link");
    rd(REG_PC, 16'h0600, "pc after call");
    run(16'h0084);
    rd(REG_PC, 16'h0500, "pc after return");
    rd(3'h4, 16'h0602, "popped link");
    rd(REG_SP, 16'h0400, "sp after return");
  endtask
  task automatic t_call_pc();
    wr(REG_PC, 16'h0700);
    run(16'h09cc);
    chk(jsc_mem_model_i.mem[10'h1ff], 16'h0700, "pc pushed");
    rd(REG_PC, 16'h0602, "pc link call");
  endtask
  task automatic t_modes();
    jsc_mem_model_i.mem[10'h180] = 16'h0420;
    jsc_mem_model_i.mem[10'h080] = 16'h0440;
    jsc_mem_model_i.mem[10'h100] = 16'h0010;
    jsc_mem_model_i.mem[10'h188] = 16'h0460;
    wr(3'h1, 16'h0300);
    wr(3'h2, 16'h0102);
    wr(3'h3, 16'h0504);
    run(16'h0059);
    rd(REG_PC, 16'h0420, "autoinc deferred jump");
    rd(3'h1, 16'h0302, "autoinc step");
    run(16'h006a);
    rd(REG_PC, 16'h0440, "autodec deferred jump");
    rd(3'h2, 16'h0100, "autodec step");
    run(16'h0063);
    rd(REG_PC, 16'h0502, "autodec jump");
    wr(3'h1, 16'h0300);
    wr(REG_PC, 16'h0200);
    run(16'h0079);
    rd(REG_PC, 16'h0460, "index deferred jump");
    run(16'h1234);
    chk(16'(ill), 16'h0000, "foreign opcode flagged");
    rd(REG_PC, 16'h0460, "foreign opcode moved pc");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_i = 1'h0;
    t_jump();
    t_mode0();
    t_index();
    t_call_ret();
    t_call_pc();
    t_modes();
    finish_test();
  end
  // All scenarios take roughly a hundred cycles; this 5000-cycle span leaves ample margin.
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
endmodule

// File: rtl/jsc_decode.sv
// Instruction classifier for the jump and subroutine control block.
`timescale 1ns/1ps
module jsc_decode
  import jsc_pkg::*;
(
  // Instruction word in
  input  wire logic [DW-1:0] instr_i,
  // Decoded fields out
  output jsc_dec_t           dec_o
);

  always_comb begin
    dec_o          = '0;
    dec_o.op       = OP_NONE;
    dec_o.mode     = instr_i[DST_MODE_LSB +: 3];
    dec_o.dst_reg  = instr_i[DST_REG_LSB +: RW];
    dec_o.link_reg = instr_i[CALL_LINK_LSB +: RW];
    if (instr_i[DW-1:JUMP_OPC_LSB] == OPC_JUMP) begin
      dec_o.op = OP_JUMP;
    end else if (instr_i[DW-1:CALL_OPC_LSB] == OPC_CALL) begin
      dec_o.op = OP_CALL;
    end else if (instr_i[DW-1:RETURN_OPC_LSB] == OPC_RETURN) begin
      dec_o.op       = OP_RETURN;
      dec_o.link_reg = instr_i[RET_LINK_LSB +: RW];
    end
  end

endmodule

// File: rtl/jsc_pkg.sv
// Shared constants and types for the jump and subroutine control block.
package jsc_pkg;

  localparam int unsigned DW = 16;
  localparam int unsigned RW = 3;

  // Opcode match fields, top bits of the instruction word.
  localparam logic [9:0]  OPC_JUMP   = 10'h001;
  localparam logic [6:0]  OPC_CALL   = 7'h04;
  localparam logic [12:0] OPC_RETURN = 13'h0010;

  // Field positions inside the instruction word.
  localparam int unsigned JUMP_OPC_LSB   = 6;
  localparam int unsigned CALL_OPC_LSB   = 9;
  localparam int unsigned RETURN_OPC_LSB = 3;
  localparam int unsigned CALL_LINK_LSB  = 6;
  localparam int unsigned RET_LINK_LSB   = 0;
  localparam int unsigned DST_MODE_LSB   = 3;
  localparam int unsigned DST_REG_LSB    = 0;

  // General register indices.
  localparam logic [RW-1:0] REG_SP = 3'h6;
  localparam logic [RW-1:0] REG_PC = 3'h7;

  // Address step of one word.
  localparam logic [DW-1:0] WORD_STEP = 16'h0002;

  // Destination addressing modes.
  localparam logic [2:0] MODE_REG      = 3'h0;
  localparam logic [2:0] MODE_DEF      = 3'h1;
  localparam logic [2:0] MODE_INC      = 3'h2;
  localparam logic [2:0] MODE_INC_DEF  = 3'h3;
  localparam logic [2:0] MODE_DEC      = 3'h4;
  localparam logic [2:0] MODE_DEC_DEF  = 3'h5;
  localparam logic [2:0] MODE_IDX      = 3'h6;
  localparam logic [2:0] MODE_IDX_DEF  = 3'h7;

  localparam logic [DW-1:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_JUMP,
    OP_CALL,
    OP_RETURN
  } jsc_op_t;

  typedef struct packed {
    jsc_op_t       op;
    logic [2:0]    mode;
    logic [RW-1:0] dst_reg;
    logic [RW-1:0] link_reg;
  } jsc_dec_t;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
  } jsc_mem_t;

endpackage

// File: rtl/jsc_top.sv
// Executes jump, subroutine call and subroutine return instructions.
// Function
// - A jump loads the program counter with the destination address of any mode except register mode 0 and leaves condition codes alone.
// - A jump or call to register mode 0 raises an illegal instruction condition and transfers nothing.
// - A jump in register deferred mode goes to the address held in the named register.
// - A new program counter that is odd raises a boundary error trap for the fetch.
// - A call first computes its destination into a temporary register before touching registers or stack.
// - A call decrements the stack pointer and then writes the old linkage register there.
// - After the push a call copies the program counter into the linkage register and loads the counter from the temporary.
// - A call with the program counter as linkage register uses the same sequence, so the return address lives on the stack.
// - A return loads the counter from the named register, pops the stack top into it and steps the stack pointer up.
`timescale 1ns/1ps
module jsc_top
  import jsc_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  // Instruction issue
  input  wire logic          instr_valid_i,
  input  wire logic [DW-1:0] instr_i,
  output logic               ready_o,
  output logic               done_o,
  output logic               illegal_o,
  output logic               boundary_err_o,
  // Register file preload and readback
  input  wire logic          reg_wr_en_i,
  input  wire logic [RW-1:0] reg_wr_sel_i,
  input  wire logic [DW-1:0] reg_wr_data_i,
  input  wire logic [RW-1:0] reg_rd_sel_i,
  output logic [DW-1:0]      reg_rd_data_o,
  // Memory port
  output logic               mem_req_o,
  output logic               mem_we_o,
  output logic [DW-1:0]      mem_addr_o,
  output logic [DW-1:0]      mem_wdata_o,
  input  wire logic          mem_ack_i,
  input  wire logic [DW-1:0] mem_rdata_i
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INDEX,
    ST_INDIRECT,
    ST_PUSH,
    ST_POP,
    ST_FINISH
  } jsc_state_t;

  typedef struct packed {
    jsc_state_t           state;
    jsc_dec_t             dec;
    logic [7:0][DW-1:0]   regs;
    logic [DW-1:0]        tmp;
    jsc_mem_t             mem;
    logic                 ready;
    logic                 done;
    logic                 illegal;
    logic                 boundary;
    logic [DW-1:0]        rd_data;
  } jsc_st_t;

  jsc_st_t  st_ff;
  jsc_st_t  nxt_st;
  jsc_dec_t dec;

  jsc_decode jsc_decode_i (
    .instr_i (instr_i),
    .dec_o   (dec)
  );

  // Starts a memory read at the given address.
  function automatic jsc_mem_t mem_read(input logic [DW-1:0] addr);
    jsc_mem_t m;
    m       = '0;
    m.req   = 1'b1;
    m.addr  = addr;
    return m;
  endfunction

  always_comb begin
    logic [DW-1:0] r_val;
    logic [DW-1:0] ea;
    logic [DW-1:0] sp_dec;
    r_val          = RESET_WORD;
    ea             = RESET_WORD;
    sp_dec         = RESET_WORD;
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.illegal = 1'b0;
    nxt_st.boundary = 1'b0;
    nxt_st.rd_data = st_ff.regs[reg_rd_sel_i];
    case (st_ff.state)
      ST_IDLE: begin
        if (instr_valid_i) begin
          nxt_st.dec   = dec;
          nxt_st.ready = 1'b0;
          r_val = st_ff.regs[dec.dst_reg];
          case (dec.op)
            OP_RETURN: begin
              // The counter takes the link value now; the pop follows.
              nxt_st.regs[REG_PC] = st_ff.regs[dec.link_reg];
              nxt_st.mem   = mem_read(st_ff.regs[REG_SP]);
              nxt_st.state = ST_POP;
            end
            OP_JUMP, OP_CALL: begin
              nxt_st.state = ST_FINISH;
              case (dec.mode)
                MODE_REG: begin
                  nxt_st.illegal  = 1'b1;
                  nxt_st.done     = 1'b1;
                  nxt_st.ready    = 1'b1;
                  nxt_st.state    = ST_IDLE;
                end
                MODE_DEF: begin
                  nxt_st.tmp = r_val;
                end
                MODE_INC: begin
                  nxt_st.tmp = r_val;
                  nxt_st.regs[dec.dst_reg] = r_val + WORD_STEP;
                end
                MODE_INC_DEF: begin
                  nxt_st.regs[dec.dst_reg] = r_val + WORD_STEP;
                  nxt_st.mem   = mem_read(r_val);
                  nxt_st.state = ST_INDIRECT;
                end
                MODE_DEC: begin
                  nxt_st.tmp = r_val - WORD_STEP;
                  nxt_st.regs[dec.dst_reg] = r_val - WORD_STEP;
                end
                MODE_DEC_DEF: begin
                  nxt_st.regs[dec.dst_reg] = r_val - WORD_STEP;
                  nxt_st.mem   = mem_read(r_val - WORD_STEP);
                  nxt_st.state = ST_INDIRECT;
                end
                default: begin
                  // Indexed modes read the index word behind the opcode.
                  nxt_st.regs[REG_PC] = st_ff.regs[REG_PC] + WORD_STEP;
                  nxt_st.mem   = mem_read(st_ff.regs[REG_PC]);
                  nxt_st.state = ST_INDEX;
                end
              endcase
              if (nxt_st.state == ST_FINISH &&
                  dec.op == OP_CALL) begin
                nxt_st.state = ST_PUSH;
              end
            end
            default: begin
              // Other opcodes belong to other units and are ignored.
              nxt_st.done     = 1'b1;
              nxt_st.ready    = 1'b1;
              nxt_st.state    = ST_IDLE;
            end
          endcase
        end else if (reg_wr_en_i) begin
          nxt_st.regs[reg_wr_sel_i] = reg_wr_data_i;
        end
      end
      ST_INDEX: begin
        if (mem_ack_i) begin
          // Base is read after the index fetch, so a counter base sees
          // the address past the index word.
          ea = st_ff.regs[st_ff.dec.dst_reg] + mem_rdata_i;
          nxt_st.mem = '0;
          if (st_ff.dec.mode == MODE_IDX_DEF) begin
            // The pointer read waits one idle cycle so that every
            // request drops after its answer.
            nxt_st.tmp   = ea;
            nxt_st.state = ST_INDIRECT;
          end else begin
            nxt_st.tmp   = ea;
            nxt_st.state = (st_ff.dec.op == OP_CALL) ? ST_PUSH : ST_FINISH;
          end
        end
      end
      ST_INDIRECT: begin
        if (!st_ff.mem.req) begin
          nxt_st.mem = mem_read(st_ff.tmp);
        end else if (mem_ack_i) begin
          nxt_st.mem   = '0;
          nxt_st.tmp   = mem_rdata_i;
          nxt_st.state = (st_ff.dec.op == OP_CALL) ? ST_PUSH : ST_FINISH;
        end
      end
      ST_PUSH: begin
        if (!st_ff.mem.req) begin
          // Stack write starts only once the destination sits in tmp.
          sp_dec = st_ff.regs[REG_SP] - WORD_STEP;
          nxt_st.regs[REG_SP] = sp_dec;
          nxt_st.mem.req   = 1'b1;
          nxt_st.mem.we    = 1'b1;
          nxt_st.mem.addr  = sp_dec;
          nxt_st.mem.wdata = st_ff.regs[st_ff.dec.link_reg];
        end else if (mem_ack_i) begin
          nxt_st.mem = '0;
          // A counter link is overwritten by tmp at once.
          nxt_st.regs[st_ff.dec.link_reg] = st_ff.regs[REG_PC];
          nxt_st.regs[REG_PC] = st_ff.tmp;
          nxt_st.state = ST_FINISH;
        end
      end
      ST_POP: begin
        if (mem_ack_i) begin
          nxt_st.mem = '0;
          nxt_st.regs[REG_SP] = st_ff.regs[REG_SP] + WORD_STEP;
          nxt_st.regs[st_ff.dec.link_reg] = mem_rdata_i;
          nxt_st.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (st_ff.dec.op == OP_JUMP) begin
          nxt_st.regs[REG_PC] = st_ff.tmp;
        end
        nxt_st.state = ST_IDLE;
        nxt_st.done  = 1'b1;
        nxt_st.ready = 1'b1;
        nxt_st.boundary = (st_ff.dec.op == OP_JUMP) ?
                          st_ff.tmp[0] : st_ff.regs[REG_PC][0];
      end
      default: begin
        nxt_st.state = ST_IDLE;
        nxt_st.ready = 1'b1;
        nxt_st.mem   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff       <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ready_o        = st_ff.ready;
  assign done_o         = st_ff.done;
  assign illegal_o      = st_ff.illegal;
  assign boundary_err_o = st_ff.boundary;
  assign reg_rd_data_o  = st_ff.rd_data;
  assign mem_req_o      = st_ff.mem.req;
  assign mem_we_o       = st_ff.mem.we;
  assign mem_addr_o     = st_ff.mem.addr;
  assign mem_wdata_o    = st_ff.mem.wdata;

endmodule
